// File: src/dot_seq_pkg.sv
// Purpose: Shared constants and types for the dot printer mechanism sequencer
// Assumes: 200 MHz system clock, timers run on a 1 us tick
// Notes: Tick counts are derived here and passed as top-level defaults
package dot_seq_pkg;
    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 5;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_FEED_PWR_MS = 10;
    localparam int T_CLUTCH_MS = 160;
    localparam int T_DOT_GAP_US = 900;
    localparam int T_STEP_MS = 2;
    localparam int FEED_PWR_TICKS = (T_FEED_PWR_MS * 1000000 + TICK_NS - 1) / TICK_NS;
    localparam int CLUTCH_TICKS = (T_CLUTCH_MS * 1000000 + TICK_NS - 1) / TICK_NS;
    localparam int DOT_GAP_TICKS = (T_DOT_GAP_US * 1000 + TICK_NS - 1) / TICK_NS;
    localparam int STEP_TICKS = (T_STEP_MS * 1000000 + TICK_NS - 1) / TICK_NS;
    localparam int TIMER_W = 20;
    localparam int PRE_W = 12;

    // ****************************************
    // Mechanism geometry
    // ****************************************
    localparam logic [5:0] BURST_LEN = 6'h22;
    localparam logic [3:0] GROUP_LEN = 4'h9;
    localparam logic [3:0] DOTS_PER_COL = 4'h7;
    localparam logic [4:0] FEED_STEPS = 5'h18;
    localparam logic [1:0] INIT_PASSES = 2'h2;
    // Full-step phase table, entry 0 is the aligned a+b position
    localparam logic [15:0] PHASE_SEQ = 16'h9c63;
    localparam logic [3:0] PHASE_ALIGN = 4'h3;

    // ****************************************
    // Selector switch
    // ****************************************
    localparam logic [1:0] SEL_TEST = 2'h0;
    localparam logic [1:0] SEL_DEV4 = 2'h1;
    localparam logic [1:0] SEL_DEV5 = 2'h2;
    localparam logic [2:0] DEV_NUM4 = 3'h4;
    localparam logic [2:0] DEV_NUM5 = 3'h5;

    typedef enum logic [3:0] {
        sHold, sAlign, sSpin, sLeave, sMeasure, sPrint, sRetract,
        sFeedPwr, sFeedStep, sWaitHome, sHomeHold, sIdle
    } seq_state_t;

    // Sensor pins from the mechanism
    typedef struct packed {
        logic extResetN;
        logic home;
        logic dot;
        logic [1:0] sel;
    } mech_in_t;

    // Drive outputs to the mechanism
    typedef struct packed {
        logic motorRunN;
        logic carriageClutchN;
        logic feedPowerEnN;
        logic [3:0] feedPhase;
        logic hammerN;
    } mech_out_t;

    localparam mech_out_t OUT_IDLE = '{1'b1, 1'b1, 1'b1, PHASE_ALIGN, 1'b1};
endpackage

// File: src/dot_printer_mechanism_sequencer.sv
// Purpose: Sequencer for a single-hammer impact dot printer mechanism
// Assumes: Sensor pins are asynchronous; line requests come from sys_clk logic
// Notes: All millisecond intervals are counted on a prescaled tick
//
// Summary of operation
// - Hold in reset while ext reset pin is low; start on its rising edge.
// - Initialise: reset state, two head passes storing start count, return home.
// - Align feed stepper with phases a and b high, c and d low.
// - Drive feed power enable low for alignment, release after about 10 ms.
// - Line start drives motor run and clutch low, motor spins disengaged.
// - About 160 ms later release clutch high to engage carriage rightward.
// - After engaging, wait for home to go low before evaluating dot pulses.
// - From home falling, count dot pulses until dot stays high about 0.9 ms.
// - Compare measured count with stored count to choose the printing start pulse.
// - Drive hammer low in step with dot pulses to print one dot.
// - Seven slots per column; pattern bit per slot decides hammer firing.
// - Slots are pulses 1-7, 10-16, 19-25, 28-34; gap pulses stay unused.
// - Line end: motor run high, clutch low, spring pulls carriage home.
// - With line feed, power enable low, stepping starts about 10 ms later.
// - After feed wait for home high, then clutch high about 160 ms later.
// - Each step is 1/144 inch; 24 steps per character line feed.
// - Read selector: self-test, device number 4, or device number 5.
`timescale 1ns/1ps
`default_nettype none

module dot_printer_mechanism_sequencer
    import dot_seq_pkg::*;
#(
    parameter int TICK_DIV = TICK_CYCLES,
    parameter int FEED_PWR_T = FEED_PWR_TICKS,
    parameter int CLUTCH_T = CLUTCH_TICKS,
    parameter int DOT_GAP_T = DOT_GAP_TICKS,
    parameter int STEP_T = STEP_TICKS
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Mechanism sensor pins
    input wire mech_in_t mechIn,
    // Mechanism drive pins
    output mech_out_t mechOut,
    // Line request from the character logic
    input wire logic lineStart,
    input wire logic [8:0] lineCols,
    input wire logic lineFeed,
    input wire logic [6:0] colData,
    output logic colTake,
    // Status
    output logic busy,
    output logic initDone,
    output logic selfTest,
    output logic [2:0] devNum
);
    // ****************************************
    // Constants at register width
    // ****************************************
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_DIV - 1);
    localparam logic [TIMER_W-1:0] FEED_PWR_LIM = TIMER_W'(FEED_PWR_T);
    localparam logic [TIMER_W-1:0] CLUTCH_LIM = TIMER_W'(CLUTCH_T);
    localparam logic [TIMER_W-1:0] GAP_LIM = TIMER_W'(DOT_GAP_T);
    localparam logic [TIMER_W-1:0] STEP_LIM = TIMER_W'(STEP_T);
    // Synchroniser starts at the pins' idle levels so no false dot edge follows reset
    localparam mech_in_t PIN_IDLE = '{extResetN: 1'b0, home: 1'b1, dot: 1'b1, sel: SEL_DEV4};

    // ****************************************
    // State record
    // ****************************************
    typedef struct packed {
        seq_state_t st;
        mech_in_t s1;
        mech_in_t s2;
        mech_in_t s3;
        mech_in_t filt;
        logic dotPrev;
        logic [PRE_W-1:0] pre;
        logic tick;
        logic [TIMER_W-1:0] tmr;
        logic [TIMER_W-1:0] gap;
        logic [7:0] dotCnt;
        logic [7:0] storedCnt;
        logic [1:0] pass;
        logic init;
        logic skip;
        logic [5:0] pos;
        logic [3:0] ofs;
        logic [6:0] pat;
        logic [8:0] cols;
        logic [4:0] steps;
        logic [1:0] phIdx;
        logic feed;
        mech_out_t mo;
        logic colTake;
        logic busy;
        logic initDone;
        logic selfTest;
        logic [2:0] devNum;
    } core_t;

    localparam core_t CORE_RESET = '{
        st: sHold, s1: PIN_IDLE, s2: PIN_IDLE, s3: PIN_IDLE, filt: PIN_IDLE, dotPrev: 1'b1,
        pre: '0, tick: 1'b0, tmr: '0, gap: '0, dotCnt: '0, storedCnt: '0,
        pass: '0, init: 1'b0, skip: 1'b0, pos: '0, ofs: '0, pat: '0,
        cols: '0, steps: '0, phIdx: '0, feed: 1'b0, mo: OUT_IDLE,
        colTake: 1'b0, busy: 1'b1, initDone: 1'b0, selfTest: 1'b0,
        devNum: DEV_NUM4
    };

    core_t c_reg;
    core_t c_next;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        logic dotFall;
        logic gapDone;
        logic tmrClutch;
        dotFall = 1'b0;
        gapDone = 1'b0;
        tmrClutch = 1'b0;
        c_next = c_reg;
        c_next.colTake = 1'b0;

        // Pin synchroniser: a level is accepted once stages two and three agree
        c_next.s1 = mechIn;
        c_next.s2 = c_reg.s1;
        c_next.s3 = c_reg.s2;
        for (int i = 0; i < $bits(mech_in_t); i++) begin
            if (c_reg.s2[i] == c_reg.s3[i]) begin
                c_next.filt[i] = c_reg.s3[i];
            end
        end
        c_next.dotPrev = c_reg.filt.dot;
        dotFall = c_reg.dotPrev && !c_reg.filt.dot;

        // Selector decode, unknown codes fall back to the normal position
        c_next.selfTest = (c_reg.filt.sel == SEL_TEST);
        c_next.devNum = (c_reg.filt.sel == SEL_DEV5) ? DEV_NUM5 : DEV_NUM4;

        // Prescaler gives the timer tick so timers stay narrow
        c_next.tick = (c_reg.pre == PRE_LAST);
        c_next.pre = c_next.tick ? '0 : c_reg.pre + 1'b1;
        if (c_reg.tick) begin
            c_next.tmr = c_reg.tmr + 1'b1;
        end
        tmrClutch = (c_reg.tmr >= CLUTCH_LIM);

        // Gap timer: runs while dot stays high, cleared by any low level
        if (c_reg.filt.dot == 1'b0) begin
            c_next.gap = '0;
        end else if (c_reg.tick && c_reg.gap != GAP_LIM) begin
            c_next.gap = c_reg.gap + 1'b1;
        end
        gapDone = (c_reg.gap == GAP_LIM);

        case (c_reg.st)
            sHold: begin
                c_next.mo = OUT_IDLE;
                if (c_reg.filt.extResetN) begin
                    c_next.st = sAlign;
                    c_next.init = 1'b1;
                    c_next.initDone = 1'b0;
                    c_next.pass = '0;
                    c_next.phIdx = '0;
                    c_next.mo.feedPhase = PHASE_ALIGN;
                    c_next.mo.feedPowerEnN = 1'b0;
                    c_next.tmr = '0;
                end
            end
            sAlign: begin
                if (c_reg.tmr >= FEED_PWR_LIM) begin
                    c_next.mo.feedPowerEnN = 1'b1;
                    // Head away from home is first returned before measuring
                    c_next.mo.motorRunN = 1'b1;
                    c_next.mo.carriageClutchN = 1'b0;
                    c_next.st = sWaitHome;
                end
            end
            sSpin: begin
                if (tmrClutch) begin
                    c_next.mo.carriageClutchN = 1'b1;
                    c_next.st = sLeave;
                end
            end
            sLeave: begin
                if (!c_reg.filt.home) begin
                    // A pulse that falls together with home is the first one counted
                    c_next.dotCnt = 8'(dotFall);
                    c_next.st = sMeasure;
                end
            end
            sMeasure: begin
                if (dotFall) begin
                    c_next.dotCnt = c_reg.dotCnt + 1'b1;
                end
                if (gapDone) begin
                    if (c_reg.init) begin
                        c_next.storedCnt = c_reg.dotCnt;
                        c_next.pass = c_reg.pass + 1'b1;
                        c_next.st = sRetract;
                    end else begin
                        // More pulses than stored: head runs early, drop one burst
                        c_next.skip = (c_reg.dotCnt > c_reg.storedCnt);
                        c_next.pos = '0;
                        c_next.ofs = '0;
                        c_next.st = sPrint;
                    end
                end
            end
            sPrint: begin
                if (dotFall && c_reg.pos != BURST_LEN) begin
                    c_next.pos = c_reg.pos + 1'b1;
                    if (c_reg.pos == '0 || c_reg.ofs == GROUP_LEN - 1'b1) begin
                        c_next.ofs = '0;
                    end else begin
                        c_next.ofs = c_reg.ofs + 1'b1;
                    end
                    // A column is fetched on the first slot of each group while columns remain and the burst is not skipped
                    if (c_next.ofs == '0 && !c_reg.skip) begin
                        if (c_reg.cols != '0) begin
                            c_next.pat = colData;
                            c_next.cols = c_reg.cols - 1'b1;
                            c_next.colTake = 1'b1;
                        end else begin
                            c_next.pat = '0;
                        end
                    end
                end
                if (gapDone && c_reg.pos != '0) begin
                    c_next.pos = '0;
                    c_next.skip = 1'b0;
                    if (c_reg.cols == '0) begin
                        c_next.st = sRetract;
                    end
                end
            end
            sRetract: begin
                c_next.mo.motorRunN = 1'b1;
                c_next.mo.carriageClutchN = 1'b0;
                c_next.tmr = '0;
                if (c_reg.feed) begin
                    c_next.mo.feedPowerEnN = 1'b0;
                    c_next.st = sFeedPwr;
                end else begin
                    c_next.st = sWaitHome;
                end
            end
            sFeedPwr: begin
                if (c_reg.tmr >= FEED_PWR_LIM) begin
                    c_next.phIdx = c_reg.phIdx + 1'b1;
                    c_next.steps = '0;
                    c_next.tmr = '0;
                    c_next.st = sFeedStep;
                end
            end
            sFeedStep: begin
                if (c_reg.tmr >= STEP_LIM) begin
                    c_next.tmr = '0;
                    if (c_reg.steps == FEED_STEPS - 1'b1) begin
                        c_next.mo.feedPowerEnN = 1'b1;
                        c_next.feed = 1'b0;
                        c_next.st = sWaitHome;
                    end else begin
                        c_next.phIdx = c_reg.phIdx + 1'b1;
                        c_next.steps = c_reg.steps + 1'b1;
                    end
                end
            end
            sWaitHome: begin
                if (c_reg.filt.home) begin
                    c_next.tmr = '0;
                    c_next.st = sHomeHold;
                end
            end
            sHomeHold: begin
                if (tmrClutch) begin
                    c_next.mo.carriageClutchN = 1'b1;
                    if (c_reg.init && c_reg.pass != INIT_PASSES) begin
                        c_next.mo.motorRunN = 1'b0;
                        c_next.mo.carriageClutchN = 1'b0;
                        c_next.tmr = '0;
                        c_next.st = sSpin;
                    end else begin
                        c_next.init = 1'b0;
                        c_next.initDone = 1'b1;
                        c_next.st = sIdle;
                    end
                end
            end
            sIdle: begin
                if (lineStart && lineCols != '0) begin
                    c_next.cols = lineCols;
                    c_next.feed = lineFeed;
                    c_next.mo.motorRunN = 1'b0;
                    c_next.mo.carriageClutchN = 1'b0;
                    c_next.tmr = '0;
                    c_next.st = sSpin;
                end else if (lineStart && lineFeed) begin
                    // Feed-only request skips the print pass
                    c_next.feed = 1'b1;
                    c_next.st = sRetract;
                end
            end
            default: begin
                c_next.st = sHold;
            end
        endcase

        // Phase outputs track the step index except while held in reset
        if (c_next.st != sHold) begin
            c_next.mo.feedPhase = PHASE_SEQ[{c_next.phIdx, 2'b00} +: 4];
        end

        // Hammer fires while the dot pulse is low in an active slot
        c_next.mo.hammerN = !(c_next.st == sPrint && !c_reg.filt.dot &&
            c_next.pos != '0 && c_next.ofs < DOTS_PER_COL &&
            !c_next.skip && c_next.pat[c_next.ofs[2:0]]);

        // External reset pin low overrides state and drive outputs; a column take from the same cycle still goes out
        if (!c_reg.filt.extResetN) begin
            c_next.st = sHold;
            c_next.mo = OUT_IDLE;
            c_next.init = 1'b0;
            c_next.initDone = 1'b0;
            c_next.feed = 1'b0;
            c_next.phIdx = '0;
        end
        c_next.busy = (c_next.st != sIdle);
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            c_reg <= CORE_RESET;
        end else begin
            c_reg <= c_next;
        end
    end

    // Outputs come straight from the state register
    assign mechOut = c_reg.mo;
    assign colTake = c_reg.colTake;
    assign busy = c_reg.busy;
    assign initDone = c_reg.initDone;
    assign selfTest = c_reg.selfTest;
    assign devNum = c_reg.devNum;
endmodule

`default_nettype wire

// File: tb/dot_seq_asserts.sv
// Purpose: Concurrent checks on the mechanism sequencer ports
// Assumes: Short timer parameters, two clocks per tick
// Notes: Windows allow a tick of prescaler slip and the sensor sync delay
`timescale 1ns/1ps
`default_nettype none
module dot_seq_asserts
    import dot_seq_pkg::*;
#(
    parameter int TICK_DIV = 2,
    parameter int CLUTCH_T = 8
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Mechanism pins
    input wire mech_in_t mechIn,
    input wire mech_out_t mechOut,
    // Status
    input wire logic colTake,
    input wire logic busy,
    input wire logic initDone,
    input wire logic selfTest,
    input wire logic [2:0] devNum
);
    // ****************************************
    // Helpers
    // ****************************************
    logic [3:0] phasePrev;

    // Previous phase, so the walk direction can be checked
    always_ff @(posedge sys_clk) begin
        phasePrev <= mechOut.feedPhase;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ****************************************
    // Properties
    // ****************************************
    hold_idle_a: assert property (
        (!mechIn.extResetN)[*6] |-> busy && mechOut.motorRunN && mechOut.feedPowerEnN)
        else $error("Outputs not idle while reset pin is low");
    align_phase_a: assert property (
        !initDone && $fell(mechOut.feedPowerEnN) |->
            mechOut.feedPhase == PHASE_ALIGN ##[8:14] mechOut.feedPowerEnN)
        else $error("Stepper alignment phase or power window wrong");
    spin_up_a: assert property (
        $fell(mechOut.motorRunN) |-> (!mechOut.carriageClutchN)[*8] ##[5:14] mechOut.carriageClutchN)
        else $error("Clutch not held for the spin-up interval");
    home_quiet_a: assert property (
        mechIn.home |-> mechOut.hammerN && !colTake)
        else $error("Hammer or column take while carriage at home");
    fire_on_dot_a: assert property (
        !mechOut.hammerN |-> !$past(mechIn.dot, 3) || !$past(mechIn.dot, 4) || !$past(mechIn.dot, 5))
        else $error("Hammer fired outside a dot pulse");
    take_pulse_a: assert property (
        colTake |=> !colTake)
        else $error("Column take longer than one cycle");
    retract_spring_a: assert property (
        $rose(mechOut.motorRunN) |-> !mechOut.carriageClutchN)
        else $error("Clutch not released when motor stops");
    feed_delay_a: assert property (
        initDone && $fell(mechOut.feedPowerEnN) |=>
            $stable(mechOut.feedPhase)[*6] ##[1:10] $changed(mechOut.feedPhase))
        else $error("First feed step not at the power-on delay");
    phase_walk_a: assert property (
        $changed(mechOut.feedPhase) |-> mechOut.feedPhase == {phasePrev[2:0], phasePrev[3]})
        else $error("Feed phase left the full-step sequence");
    home_settle_a: assert property (
        $rose(mechOut.carriageClutchN) && mechOut.motorRunN |-> $past(mechIn.home, 12))
        else $error("Return clutch engaged too soon after home");
    sel_decode_a: assert property (
        (mechIn.sel == SEL_DEV5)[*8] |-> devNum == DEV_NUM5 && !selfTest)
        else $error("Selector not decoded to the second device");
endmodule

bind dot_printer_mechanism_sequencer dot_seq_asserts #(
    .TICK_DIV(TICK_DIV),
    .CLUTCH_T(CLUTCH_T)
) chk (
    .sys_clk(sys_clk), .rst(rst), .mechIn(mechIn), .mechOut(mechOut), .colTake(colTake),
    .busy(busy), .initDone(initDone), .selfTest(selfTest), .devNum(devNum)
);
`default_nettype wire

// File: tb/mech_model.sv
// Purpose: Behavioural print mechanism: carriage, home and dot sensors
// Assumes: Pins change just after the falling clock edge
// Notes: Lead pulse count sets the measured start timing value
`timescale 1ns/1ps
`default_nettype none
module mech_model
    import dot_seq_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Drive pins from the sequencer
    input wire mech_out_t mechOut,
    // Pulses seen between leaving home and the first ridge gap
    input wire logic [5:0] lead,
    // Sensor pins and burst tally
    output var logic home,
    output var logic dot,
    output var logic [7:0] bursts
);
    // One shaped dot pulse, low then high for three clocks each
    task automatic pulse();
        dot = 1'b0;
        repeat (3) @(negedge sys_clk);
        dot = 1'b1;
        repeat (3) @(negedge sys_clk);
    endtask

    // Carriage runs while engaged; the spring brings it back when released
    initial begin
        home = 1'b1;
        dot = 1'b1;
        bursts = 8'h0;
        forever begin
            @(negedge sys_clk);
            if (mechOut.motorRunN === 1'b0 && mechOut.carriageClutchN === 1'b1 && home) begin
                repeat (20) @(negedge sys_clk);
                home = 1'b0;
                repeat (lead) pulse();
                // Gap is long so the sequencer stops before the next burst
                repeat (40) @(negedge sys_clk);
                while (mechOut.motorRunN === 1'b0 && mechOut.carriageClutchN === 1'b1) begin
                    repeat (34) pulse();
                    bursts++;
                    repeat (40) @(negedge sys_clk);
                end
            end else if (mechOut.motorRunN === 1'b1 && !mechOut.carriageClutchN && !home) begin
                repeat (30) @(negedge sys_clk);
                home = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/test_dot_printer_mechanism_sequencer.sv
// Purpose: Self-checking bench for the mechanism sequencer
// Assumes: Short timers, one tick per two clocks
// Notes: Inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module test_dot_printer_mechanism_sequencer
    import dot_seq_pkg::*;
();
    logic sys_clk, rst, extN, lineStart, lineFeed, colTake, busy, initDone, selfTest, home, dot;
    logic [1:0] sel;
    logic [8:0] lineCols;
    logic [6:0] colData;
    logic [2:0] devNum;
    logic [5:0] lead;
    logic [7:0] bursts;
    mech_in_t mechIn;
    mech_out_t mechOut;
    int miscompares, checkCount, hamCnt, takeCnt, stepCnt, runCnt;

    assign mechIn = '{extN, home, dot, sel};

    dot_printer_mechanism_sequencer #(.TICK_DIV(2), .FEED_PWR_T(5), .CLUTCH_T(8),
        .DOT_GAP_T(6), .STEP_T(3)) dut (
        .sys_clk(sys_clk), .rst(rst), .mechIn(mechIn), .mechOut(mechOut),
        .lineStart(lineStart), .lineCols(lineCols), .lineFeed(lineFeed), .colData(colData),
        .colTake(colTake), .busy(busy), .initDone(initDone), .selfTest(selfTest),
        .devNum(devNum));

    mech_model mech (.sys_clk(sys_clk), .mechOut(mechOut), .lead(lead), .home(home),
        .dot(dot), .bursts(bursts));

    // ****************************************
    // Clock and event counters
    // ****************************************
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(negedge mechOut.hammerN) hamCnt++;
    always @(negedge mechOut.motorRunN) runCnt++;
    always @(mechOut.feedPhase) stepCnt++;
    always @(posedge sys_clk) begin
        if (colTake === 1'b1) takeCnt++;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checkCount++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One line, a second request while busy, then the tallies
    task automatic run_line(input logic [8:0] cols, input logic [6:0] pat, input logic fd,
        input logic [5:0] ld, input logic [7:0] expBursts);
        logic [7:0] b0;
        int n;
        b0 = bursts;
        lead = ld;
        lineCols = cols;
        colData = pat;
        lineFeed = fd;
        hamCnt = 0;
        takeCnt = 0;
        stepCnt = 0;
        runCnt = 0;
        lineStart = 1'b1;
        @(negedge sys_clk);
        lineStart = 1'b0;
        check("busy", 1, busy);
        check("motor run", 0, mechOut.motorRunN);
        check("clutch", 0, mechOut.carriageClutchN);
        @(negedge sys_clk);
        lineStart = 1'b1;
        @(negedge sys_clk);
        lineStart = 1'b0;
        for (n = 0; n < 20000 && busy !== 1'b0; n++) @(negedge sys_clk);
        repeat (8) @(negedge sys_clk);
        check("busy after line", 0, busy);
        check("lines run", 1, runCnt);
        check("columns taken", cols, takeCnt);
        check("hammer strikes", cols * $countones(pat), hamCnt);
        check("bursts used", expBursts, bursts - b0);
        check("feed steps", fd ? 24 : 0, stepCnt);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic test_reset_hold();
        int n;
        runCnt = 0;
        repeat (40) @(negedge sys_clk);
        check("busy in hold", 1, busy);
        check("init in hold", 0, initDone);
        check("feed power in hold", 1, mechOut.feedPowerEnN);
        extN = 1'b1;
        for (n = 0; n < 20000 && initDone !== 1'b1; n++) @(negedge sys_clk);
        repeat (4) @(negedge sys_clk);
        check("init passes", 2, runCnt);
        check("idle after init", 0, busy);
        check("aligned phase", PHASE_ALIGN, mechOut.feedPhase);
        $display("Test reset hold and init done");
    endtask

    task automatic test_refused();
        runCnt = 0;
        lineCols = 9'h0;
        lineFeed = 1'b0;
        lineStart = 1'b1;
        @(negedge sys_clk);
        lineStart = 1'b0;
        repeat (10) @(negedge sys_clk);
        check("empty request busy", 0, busy);
        check("empty request motor", 0, runCnt);
        $display("Test empty request done");
    endtask

    task automatic test_full_columns();
        run_line(9'h4, 7'h7f, 1'b0, 6'h5, 8'h1); // gap pulses must stay silent
        $display("Test full columns done");
    endtask

    task automatic test_feed_two_bursts();
        run_line(9'h5, 7'h55, 1'b1, 6'h5, 8'h2); // last burst leaves groups blank
        $display("Test feed two bursts done");
    endtask

    task automatic test_late_start();
        run_line(9'h4, 7'h2a, 1'b0, 6'h6, 8'h2); // longer lead skips first burst
        $display("Test late start done");
    endtask

    // Feed-only request: no print pass, motor stays off
    task automatic test_feed_only();
        stepCnt = 0;
        runCnt = 0;
        lineCols = 9'h0;
        lineFeed = 1'b1;
        lineStart = 1'b1;
        @(negedge sys_clk);
        lineStart = 1'b0;
        check("feed only busy", 1, busy);
        @(negedge sys_clk);
        check("feed only power", 0, mechOut.feedPowerEnN);
        repeat (400) @(negedge sys_clk);
        check("feed only steps", 24, stepCnt);
        check("feed only motor", 0, runCnt);
        check("feed only clutch", 1, mechOut.carriageClutchN);
        check("feed only idle", 0, busy);
        lineFeed = 1'b0;
        $display("Test feed only done");
    endtask

    task automatic test_selector();
        for (int i = 0; i < 3; i++) begin
            sel = i[1:0];
            repeat (12) @(negedge sys_clk);
            check("self test", i == 0, selfTest);
            check("device number", i == 2 ? DEV_NUM5 : DEV_NUM4, devNum);
        end
        sel = SEL_DEV4;
        $display("Test selector done");
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        extN = 1'b0;
        sel = SEL_DEV4;
        lineStart = 1'b0;
        lineCols = 9'h0;
        lineFeed = 1'b0;
        colData = 7'h0;
        lead = 6'h5;
        repeat (5) @(negedge sys_clk);
        rst = 1'b0;
        test_reset_hold();
        test_refused();
        test_full_columns();
        test_feed_two_bursts();
        test_late_start();
        test_feed_only();
        test_selector();
        wrap_up();
    end

    // Watchdog: the whole run needs a few thousand clocks, allow over fifteen times more
    initial begin
        #250000;
        miscompares++;
        wrap_up();
    end
endmodule
`default_nettype wire
